// ==== ssq_regs.vh ====
`ifndef SSQ_REGS_VH
`define SSQ_REGS_VH

// Register byte offsets on the AXI4-Lite slave.
`define SSQ_OFF_STRAP 8'h00
`define SSQ_OFF_PHASE 8'h04
`define SSQ_OFF_CHAIN 8'h08
`define SSQ_OFF_STATE 8'h0C
`define SSQ_OFF_INT_STAT 8'h10
`define SSQ_OFF_INT_MASK 8'h14

// Strap level codes as delivered by the strap digitiser.
`define SSQ_LVL_LOW 2'h0
`define SSQ_LVL_OPEN 2'h1
`define SSQ_LVL_HIGH 2'h2
`define SSQ_LVL_RES 2'h3

// Address decode: base address and the resistor count.
`define SSQ_ADDR_BASE 7'h20
`define SSQ_ADDR_LAST 7'h3D
`define SSQ_ADDR_RES_CNT 5'h1E
`define SSQ_CFG_RES_CNT 5'h0F

// Sync pin direction codes.
`define SSQ_SYNC_IN 2'h0
`define SSQ_SYNC_AUTO 2'h1
`define SSQ_SYNC_OUT 2'h2

// Role codes.
`define SSQ_ROLE_NONE 3'h0
`define SSQ_ROLE_FIRST 3'h1
`define SSQ_ROLE_LAST 3'h2
`define SSQ_ROLE_MIDDLE 3'h3
`define SSQ_ROLE_TRACK 3'h4

// Phase in steps of 22.5 degrees; 16 steps is 360 degrees.
`define SSQ_PHASE_MAX 5'h10
`define SSQ_PHASE_OVR_BIT 8

// Chain register fields.
`define SSQ_CH_PREV_V 7
`define SSQ_CH_NEXT_V 15
`define SSQ_CH_EN 16

// Interrupt status bits.
`define SSQ_INT_ON_DONE 0
`define SSQ_INT_OFF_DONE 1
`define SSQ_INT_PH_REFUSED 2
`define SSQ_INT_W 3

// Timing: clock period, peer frame bit time, strap settle time, in ns.
`define SSQ_CLK_NS 10
`define SSQ_BIT_NS 10000
`define SSQ_STRAP_SETTLE_NS 1000000

`endif

// ==== ssq_sequencer.v ====
// How it works
// - Address strap low, open, high give addresses 0x20, 0x21, 0x22.
// - Up to 30 strap resistors give consecutive addresses 0x20 to 0x3D.
// - Strapped addresses are right-justified seven-bit, no direction bit.
// - Default phase is low address bits times 45 degrees.
// - Host may override phase, 0 to 360 degrees in 22.5 degree steps.
// - Config strap position within its group sets sync pin direction.
// - Config strap group selects none, first, last, middle or tracking role.
// - Autonomous sequencing forces the address-derived phase offset.
// - Sequencing events travel between members over the shared peer bus.
// - Turn-on runs from lowest address upward until all are on.
// - Turn-off starts at highest address and runs downward.
// - Host-set predecessor and successor form the chain and free the phase.
// - Shared enable high starts sequenced turn-on, low starts turn-off.
// - The peer bus is only ever pulled low, never driven high.
// - Bus slave provides an active-low alert output for pending events enabled in the interrupt mask.
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ssq_regs.vh"

module ssq_sequencer #(
   parameter [31:0] STRAP_SETTLE_CYC = `SSQ_STRAP_SETTLE_NS / `SSQ_CLK_NS,
   parameter [15:0] BIT_CYC = `SSQ_BIT_NS / `SSQ_CLK_NS
) (
   input wire clk,
   input wire rst_n,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [1:0] address_strap_pin_level,
   input wire [4:0] address_strap_pin_res,
   input wire [1:0] cfg_strap_level,
   input wire [4:0] cfg_strap_res,
   input wire enable_pin,
   input wire rail_good,
   input wire peer_event_bus_in,
   output reg peer_event_bus_out,
   output reg peer_event_bus_oe,
   output reg rail_on,
   output reg [6:0] bus_addr,
   output reg [4:0] phase_offset,
   output reg [1:0] sync_dir,
   output reg [2:0] seq_role,
   output reg strap_done,
   output reg irq,
   output reg fault_alert_line_n
);

   localparam [2:0] ST_OFF = 3'h0;
   localparam [2:0] ST_WAIT_ON = 3'h1;
   localparam [2:0] ST_RAMP_ON = 3'h2;
   localparam [2:0] ST_ON = 3'h3;
   localparam [2:0] ST_WAIT_OFF = 3'h4;
   localparam [2:0] ST_RAMP_OFF = 3'h5;

   // Byte-lane merge of a write into an existing register value.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = data[i*8 +: 8];
            end
         end
      end
   endfunction

   // Default phase in 22.5 degree steps: two steps per address count.
   function [4:0] addr_phase;
      input [6:0] a;
      begin
         addr_phase = {1'b0, a[2:0], 1'b0};
      end
   endfunction

   // Two-flop synchronisers for every pin input.
   reg [1:0] al_s1_r, al_s2_r, cl_s1_r, cl_s2_r;
   reg [4:0] ar_s1_r, ar_s2_r, cr_s1_r, cr_s2_r;
   reg en_s1_r, en_s2_r, rg_s1_r, rg_s2_r, pb_s1_r, pb_s2_r, pb_d_r;
   always @(posedge clk) begin
      al_s1_r <= address_strap_pin_level;
      al_s2_r <= al_s1_r;
      ar_s1_r <= address_strap_pin_res;
      ar_s2_r <= ar_s1_r;
      cl_s1_r <= cfg_strap_level;
      cl_s2_r <= cl_s1_r;
      cr_s1_r <= cfg_strap_res;
      cr_s2_r <= cr_s1_r;
      en_s1_r <= enable_pin;
      en_s2_r <= en_s1_r;
      rg_s1_r <= rail_good;
      rg_s2_r <= rg_s1_r;
      pb_s1_r <= peer_event_bus_in;
      pb_s2_r <= pb_s1_r;
      pb_d_r <= pb_s2_r;
   end

   // Strap capture: wait for the strap network to settle, then latch once.
   // Later strap movement is ignored so the address can never shift live.
   reg [31:0] settle_cnt_r;
   // Config resistors come in threes: the group is the role, the place sync.
   wire [4:0] cfg_grp = cr_s2_r / 5'h03;
   wire [4:0] cfg_pos = cr_s2_r - cfg_grp * 5'h03;
   always @(posedge clk) begin
      if (!rst_n) begin
         settle_cnt_r <= 32'h0;
         strap_done <= 1'b0;
         bus_addr <= `SSQ_ADDR_BASE;
         sync_dir <= `SSQ_SYNC_IN;
         seq_role <= `SSQ_ROLE_NONE;
      end else if (!strap_done) begin
         settle_cnt_r <= settle_cnt_r + 32'h1;
         if (settle_cnt_r == STRAP_SETTLE_CYC - 32'h1) begin
            strap_done <= 1'b1;
            // Right-justified seven-bit address, no direction bit.
            case (al_s2_r)
               `SSQ_LVL_LOW: bus_addr <= `SSQ_ADDR_BASE;
               `SSQ_LVL_OPEN: bus_addr <= 7'h21;
               `SSQ_LVL_HIGH: bus_addr <= 7'h22;
               default: begin
                  // Out-of-range codes clamp to the last address.
                  if (ar_s2_r < `SSQ_ADDR_RES_CNT) begin
                     bus_addr <= `SSQ_ADDR_BASE + {2'b00, ar_s2_r};
                  end else begin
                     bus_addr <= `SSQ_ADDR_LAST;
                  end
               end
            endcase
            case (cl_s2_r)
               `SSQ_LVL_LOW: sync_dir <= `SSQ_SYNC_IN;
               `SSQ_LVL_OPEN: sync_dir <= `SSQ_SYNC_AUTO;
               `SSQ_LVL_HIGH: sync_dir <= `SSQ_SYNC_OUT;
               default: begin
                  if (cr_s2_r < `SSQ_CFG_RES_CNT) begin
                     sync_dir <= cfg_pos[1:0];
                     case (cfg_grp)
                        5'h01: seq_role <= `SSQ_ROLE_FIRST;
                        5'h02: seq_role <= `SSQ_ROLE_LAST;
                        5'h03: seq_role <= `SSQ_ROLE_MIDDLE;
                        5'h04: seq_role <= `SSQ_ROLE_TRACK;
                        default: seq_role <= `SSQ_ROLE_NONE;
                     endcase
                  end
               end
            endcase
         end
      end
   end

   // Host-writable configuration.
   reg [4:0] ph_ovr_r;
   reg ph_ovr_en_r;
   reg [15:0] chain_r;
   reg chain_en_r;
   reg [`SSQ_INT_W-1:0] int_stat_r, int_mask_r;

   wire auto_seq = (seq_role == `SSQ_ROLE_FIRST) ||
      (seq_role == `SSQ_ROLE_LAST) || (seq_role == `SSQ_ROLE_MIDDLE);
   wire seq_active = auto_seq || chain_en_r;
   wire [6:0] pred_addr = chain_en_r ? chain_r[6:0] :
      bus_addr - 7'h01;
   wire [6:0] succ_addr = chain_en_r ? chain_r[14:8] :
      bus_addr + 7'h01;
   wire has_pred = chain_en_r ? chain_r[`SSQ_CH_PREV_V] :
      (seq_role != `SSQ_ROLE_FIRST);
   wire has_succ = chain_en_r ? chain_r[`SSQ_CH_NEXT_V] :
      (seq_role != `SSQ_ROLE_LAST);

   // Phase: autonomous mode pins it to the address; chain mode frees it.
   always @(posedge clk) begin
      if (!rst_n) begin
         phase_offset <= 5'h00;
      end else if (auto_seq && !chain_en_r) begin
         phase_offset <= addr_phase(bus_addr);
      end else if (ph_ovr_en_r) begin
         phase_offset <= ph_ovr_r;
      end else begin
         phase_offset <= addr_phase(bus_addr);
      end
   end

   // Peer bus receiver: start bit, 7 address bits MSB first, direction.
   // Sampling at mid-bit tolerates the slow open-drain rising edge.
   reg rx_busy_r, rx_valid_r;
   reg [15:0] rx_cnt_r;
   reg [3:0] rx_bits_r;
   reg [7:0] rx_sh_r;
   always @(posedge clk) begin
      rx_valid_r <= 1'b0;
      if (!rst_n) begin
         rx_busy_r <= 1'b0;
         rx_cnt_r <= 16'h0;
         rx_bits_r <= 4'h0;
         rx_sh_r <= 8'h00;
      end else if (!rx_busy_r) begin
         if (pb_d_r && !pb_s2_r) begin
            rx_busy_r <= 1'b1;
            rx_cnt_r <= {1'b0, BIT_CYC[15:1]};
            rx_bits_r <= 4'h0;
         end
      end else if (rx_cnt_r != 16'h0) begin
         rx_cnt_r <= rx_cnt_r - 16'h1;
      end else begin
         rx_cnt_r <= BIT_CYC - 16'h1;
         rx_bits_r <= rx_bits_r + 4'h1;
         if (rx_bits_r == 4'h0) begin
            // A glitch shorter than half a bit is not a start bit.
            rx_busy_r <= !pb_s2_r;
         end else begin
            rx_sh_r <= {rx_sh_r[6:0], pb_s2_r};
            if (rx_bits_r == 4'h8) begin
               rx_busy_r <= 1'b0;
               rx_valid_r <= 1'b1;
            end
         end
      end
   end

   wire pred_on_evt = rx_valid_r && rx_sh_r[0] &&
      (rx_sh_r[7:1] == pred_addr);
   wire succ_off_evt = rx_valid_r && !rx_sh_r[0] &&
      (rx_sh_r[7:1] == succ_addr);
   reg pred_on_seen_r, succ_off_seen_r;

   // Peer bus transmitter; it only ever pulls the line low.
   reg tx_busy_r, tx_start_r, tx_dir_r;
   reg [15:0] tx_cnt_r;
   reg [3:0] tx_bits_r;
   reg [9:0] tx_sh_r;
   always @(posedge clk) begin
      peer_event_bus_out <= 1'b0;
      if (!rst_n) begin
         tx_busy_r <= 1'b0;
         tx_cnt_r <= 16'h0;
         tx_bits_r <= 4'h0;
         tx_sh_r <= 10'h3FF;
         peer_event_bus_oe <= 1'b0;
      end else if (!tx_busy_r) begin
         peer_event_bus_oe <= 1'b0;
         if (tx_start_r) begin
            tx_busy_r <= 1'b1;
            tx_sh_r <= {1'b0, bus_addr, tx_dir_r, 1'b1};
            tx_cnt_r <= BIT_CYC - 16'h1;
            tx_bits_r <= 4'h0;
            peer_event_bus_oe <= 1'b1;
         end
      end else if (tx_cnt_r != 16'h0) begin
         tx_cnt_r <= tx_cnt_r - 16'h1;
      end else begin
         tx_cnt_r <= BIT_CYC - 16'h1;
         tx_bits_r <= tx_bits_r + 4'h1;
         tx_sh_r <= {tx_sh_r[8:0], 1'b1};
         peer_event_bus_oe <= !tx_sh_r[8];
         if (tx_bits_r == 4'h9) begin
            tx_busy_r <= 1'b0;
            peer_event_bus_oe <= 1'b0;
         end
      end
   end

   // Sequencer. Without a role or chain, the rail simply follows enable.
   reg [2:0] st_r;
   reg on_done_r, off_done_r;
   always @(posedge clk) begin
      tx_start_r <= 1'b0;
      on_done_r <= 1'b0;
      off_done_r <= 1'b0;
      if (!rst_n || !strap_done) begin
         st_r <= ST_OFF;
         rail_on <= 1'b0;
         tx_dir_r <= 1'b0;
         pred_on_seen_r <= 1'b0;
         succ_off_seen_r <= 1'b0;
      end else begin
         // Events are remembered so an early peer frame is not lost.
         if (!en_s2_r) begin
            pred_on_seen_r <= 1'b0;
         end else if (pred_on_evt) begin
            pred_on_seen_r <= 1'b1;
         end
         if (en_s2_r) begin
            succ_off_seen_r <= 1'b0;
         end else if (succ_off_evt) begin
            succ_off_seen_r <= 1'b1;
         end
         case (st_r)
            ST_OFF: begin
               if (en_s2_r) begin
                  st_r <= ST_WAIT_ON;
               end
            end
            ST_WAIT_ON: begin
               if (!en_s2_r) begin
                  st_r <= ST_OFF;
               end else if (!seq_active || !has_pred ||
                  pred_on_seen_r || pred_on_evt) begin
                  st_r <= ST_RAMP_ON;
                  rail_on <= 1'b1;
               end
            end
            ST_RAMP_ON: begin
               if (!en_s2_r) begin
                  st_r <= ST_ON;
               end else if (rg_s2_r) begin
                  st_r <= ST_ON;
                  on_done_r <= 1'b1;
                  tx_start_r <= seq_active;
                  tx_dir_r <= 1'b1;
               end
            end
            ST_ON: begin
               if (!en_s2_r) begin
                  st_r <= ST_WAIT_OFF;
               end
            end
            ST_WAIT_OFF: begin
               if (en_s2_r) begin
                  st_r <= ST_ON;
               end else if (!seq_active || !has_succ ||
                  succ_off_seen_r || succ_off_evt) begin
                  st_r <= ST_RAMP_OFF;
                  rail_on <= 1'b0;
               end
            end
            ST_RAMP_OFF: begin
               if (!rg_s2_r) begin
                  st_r <= ST_OFF;
                  off_done_r <= 1'b1;
                  tx_start_r <= seq_active;
                  tx_dir_r <= 1'b0;
               end
            end
            default: begin
               st_r <= ST_OFF;
               rail_on <= 1'b0;
            end
         endcase
      end
   end

   // AXI4-Lite write channel: address and data accepted in either order.
   reg [7:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg ph_refused;
   reg [31:0] wmerge;
   wire [31:0] cmerge = merge({15'h0, chain_en_r, chain_r},
      wdata_r, wstrb_r);
   wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire [`SSQ_INT_W-1:0] evt = {ph_refused, off_done_r, on_done_r};
   reg [`SSQ_INT_W-1:0] w1c, int_nxt;
   always @* begin
      ph_refused = 1'b0;
      w1c = {`SSQ_INT_W{1'b0}};
      wmerge = merge({23'h0, ph_ovr_en_r, 3'h0, ph_ovr_r},
         wdata_r, wstrb_r);
      if (do_write && awaddr_r == `SSQ_OFF_PHASE) begin
         ph_refused = wmerge[4:0] > `SSQ_PHASE_MAX;
      end
      if (do_write && awaddr_r == `SSQ_OFF_INT_STAT && wstrb_r[0]) begin
         w1c = wdata_r[`SSQ_INT_W-1:0];
      end
      // A new event wins over a clear in the same cycle.
      int_nxt = (int_stat_r & ~w1c) | evt;
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         ph_ovr_r <= 5'h00;
         ph_ovr_en_r <= 1'b0;
         chain_r <= 16'h0;
         chain_en_r <= 1'b0;
         int_stat_r <= {`SSQ_INT_W{1'b0}};
         int_mask_r <= {`SSQ_INT_W{1'b0}};
         irq <= 1'b0;
         fault_alert_line_n <= 1'b1;
      end else begin
         int_stat_r <= int_nxt;
         irq <= |(int_nxt & int_mask_r);
         fault_alert_line_n <= ~|(int_nxt & int_mask_r);
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            case (awaddr_r)
               `SSQ_OFF_PHASE: begin
                  if (!ph_refused) begin
                     ph_ovr_r <= wmerge[4:0];
                     ph_ovr_en_r <= wmerge[`SSQ_PHASE_OVR_BIT];
                  end
               end
               `SSQ_OFF_CHAIN: begin
                  chain_r <= cmerge[15:0];
                  chain_en_r <= cmerge[`SSQ_CH_EN];
               end
               `SSQ_OFF_INT_STAT: begin
               end
               `SSQ_OFF_INT_MASK: begin
                  if (wstrb_r[0]) begin
                     int_mask_r <= wdata_r[`SSQ_INT_W-1:0];
                  end
               end
               `SSQ_OFF_STRAP, `SSQ_OFF_STATE: begin
               end
               default: s_axi_bresp <= 2'h2;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // AXI4-Lite read channel; unmapped offsets answer SLVERR with zero.
   always @(posedge clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         case (s_axi_araddr)
            `SSQ_OFF_STRAP: s_axi_rdata <= {15'h0, strap_done, 3'h0,
               seq_role, 1'h0, sync_dir, bus_addr};
            `SSQ_OFF_PHASE: s_axi_rdata <= {11'h0, phase_offset, 7'h0,
               ph_ovr_en_r, 3'h0, ph_ovr_r};
            `SSQ_OFF_CHAIN: s_axi_rdata <= {15'h0, chain_en_r, chain_r};
            `SSQ_OFF_STATE: s_axi_rdata <= {25'h0, tx_busy_r, rg_s2_r,
               rail_on, en_s2_r, st_r};
            `SSQ_OFF_INT_STAT: s_axi_rdata <= {29'h0, int_stat_r};
            `SSQ_OFF_INT_MASK: s_axi_rdata <= {29'h0, int_mask_r};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule // ssq_sequencer

// ==== ssq_chk_sva.sv ====
`timescale 1ns/1ps
// Port-level checker for strap decode, phase, alert and peer line use.
module ssq_chk #(
   parameter [31:0] STRAP_SETTLE_CYC = 32'h0000000A,
   parameter [15:0] BIT_CYC = 16'h0008
) (
   input wire clk,
   input wire rst_n,
   input wire [1:0] address_strap_pin_level,
   input wire [4:0] address_strap_pin_res,
   input wire [1:0] cfg_strap_level,
   input wire [4:0] cfg_strap_res,
   input wire peer_event_bus_out,
   input wire peer_event_bus_oe,
   input wire [6:0] bus_addr,
   input wire [4:0] phase_offset,
   input wire [1:0] sync_dir,
   input wire [2:0] seq_role,
   input wire strap_done,
   input wire irq,
   input wire fault_alert_line_n
);
   wire [1:0] al = address_strap_pin_level;
   wire [4:0] ar = address_strap_pin_res;
   wire [1:0] cl = cfg_strap_level;
   wire [4:0] cr = cfg_strap_res;
   reg [15:0] run_r;

   // Length of the current pull, so a slot cut short shows up.
   always @(posedge clk) begin
      if (!rst_n)
         run_r <= 16'h0000;
      else
         run_r <= peer_event_bus_oe ? run_r + 16'h0001 : 16'h0000;
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_tri;
      $rose(strap_done) && al != 2'h3 |-> bus_addr == 7'h20 + {5'h00, al};
   endproperty
   a_tri: assert property (p_tri) else $error("level address wrong");
   property p_res;
      $rose(strap_done) && al == 2'h3 && ar < 5'h1E
         |-> bus_addr == 7'h20 + {2'h0, ar};
   endproperty
   a_res: assert property (p_res) else $error("resistor address");
   property p_ph;
      $rose(strap_done)
         |-> ##[0:3] phase_offset == {1'h0, bus_addr[2:0], 1'h0};
   endproperty
   a_ph: assert property (p_ph) else $error("default phase wrong");
   property p_cfg;
      $rose(strap_done) && cl == 2'h3 && cr < 5'h0F
         |-> {2'h0, seq_role} == cr / 5'h03 && {3'h0, sync_dir} == cr % 5'h03;
   endproperty
   a_cfg: assert property (p_cfg) else $error("config decode");
   property p_od;
      peer_event_bus_oe |-> !peer_event_bus_out;
   endproperty
   a_od: assert property (p_od) else $error("peer line driven high");
   property p_bit;
      $fell(peer_event_bus_oe) |-> run_r % BIT_CYC == 16'h0000;
   endproperty
   a_bit: assert property (p_bit) else $error("peer slot length");
   property p_alert;
      fault_alert_line_n != irq;
   endproperty
   a_alert: assert property (p_alert) else $error("alert level");
   property p_hold;
      strap_done && $past(strap_done)
         |-> $stable(bus_addr) && $stable(seq_role) && $stable(sync_dir);
   endproperty
   a_hold: assert property (p_hold) else $error("strap value moved");
endmodule // ssq_chk

bind ssq_sequencer ssq_chk #(.STRAP_SETTLE_CYC(STRAP_SETTLE_CYC),
   .BIT_CYC(BIT_CYC)) u_chk (.*);

// ==== ssq_peer.sv ====
`timescale 1ns/1ps
// Peer converters on the wired event line, plus the local power stage.
module ssq_peer #(
   parameter [15:0] BIT_CYC = 16'h0008
) (
   input wire clk,
   input wire send,
   input wire [7:0] frame,
   input wire rail_on,
   output wire rail_good,
   output wire pull
);
   reg [9:0] sh_r = 10'h000;
   reg [3:0] slot_r = 4'h0;
   reg [15:0] cnt_r = 16'h0000;
   reg [39:0] rg_r = 40'h0000000000;

   // Start, address MSB first, direction, stop; one slot per bit time.
   always @(posedge clk) begin
      rg_r <= {rg_r[38:0], rail_on};
      if (send) begin
         sh_r <= {1'h0, frame, 1'h1};
         slot_r <= 4'hA;
         cnt_r <= 16'h0000;
      end else if (slot_r != 4'h0) begin
         cnt_r <= cnt_r + 16'h0001;
         if (cnt_r == BIT_CYC - 16'h0001) begin
            cnt_r <= 16'h0000;
            sh_r <= {sh_r[8:0], 1'h1};
            slot_r <= slot_r - 4'h1;
         end
      end
   end

   // The rail is slow to regulate, so our frames never overlap the peers'.
   assign rail_good = rg_r[39];
   // Only ever pulls low; a released line returns to the pull-up.
   assign pull = (slot_r != 4'h0) && !sh_r[9];
endmodule // ssq_peer

// ==== tb_strap_address_phase_sequencer.sv ====
`timescale 1ns/1ps
`include "ssq_regs.vh"
`define CHK(a, b) begin \
   tests_run = tests_run + 1; \
   if ((a) !== (b)) begin \
      fails = fails + 1; \
      $display("[FAIL] %0t got %0h exp %0h", $time, a, b); \
   end \
end

module tb_strap_address_phase_sequencer;
   integer fails = 0, tests_run = 0;
   reg clk = 1'h0, rst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   reg s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   reg enable_pin = 1'h0, send = 1'h0;
   reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, frame = 8'h00;
   reg [31:0] s_axi_wdata = 32'h00000000, d;
   reg [3:0] s_axi_wstrb = 4'hF;
   reg [1:0] address_strap_pin_level = 2'h0, cfg_strap_level = 2'h0, r;
   reg [4:0] address_strap_pin_res = 5'h00, cfg_strap_res = 5'h00;
   reg [8:0] f;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, strap_done, irq, fault_alert_line_n;
   wire [1:0] s_axi_bresp, s_axi_rresp, sync_dir;
   wire [31:0] s_axi_rdata;
   wire peer_event_bus_out, peer_event_bus_oe, rail_on, rail_good, pull;
   wire [6:0] bus_addr;
   wire [4:0] phase_offset;
   wire [2:0] seq_role;
   // Wired line with a pull-up: low while any party pulls it.
   wire peer_event_bus_in = !(peer_event_bus_oe && !peer_event_bus_out ||
      pull);

   ssq_sequencer #(.STRAP_SETTLE_CYC(32'h0000000A), .BIT_CYC(16'h0008))
      dut (.*);
   ssq_peer #(.BIT_CYC(16'h0008)) peer_m (.clk(clk), .send(send),
      .frame(frame), .rail_on(rail_on), .rail_good(rail_good), .pull(pull));

   // 100 MHz clock.
   always #5 clk = ~clk;

   task test_done;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   // Address and data go out together; each drops once it is taken.
   task wr(input [7:0] a, input [31:0] v);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         @(posedge clk);
         while (s_axi_awvalid || s_axi_wvalid) begin
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            @(posedge clk);
         end
         while (s_axi_bvalid !== 1'h1) @(posedge clk);
         r = s_axi_bresp;
         s_axi_bready <= 1'h0;
         repeat (3) @(posedge clk);
      end
   endtask

   task rd(input [7:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         @(posedge clk);
         while (s_axi_arready !== 1'h1) @(posedge clk);
         s_axi_arvalid <= 1'h0;
         @(posedge clk);
         while (s_axi_rvalid !== 1'h1) @(posedge clk);
         d = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= 1'h0;
         repeat (3) @(posedge clk);
      end
   endtask

   // Straps are read once after reset, so every setting needs a reset.
   task boot(input [1:0] la, input [4:0] ra, input [1:0] lc, input [4:0] rc);
      begin
         rst_n <= 1'h0;
         enable_pin <= 1'h0;
         address_strap_pin_level <= la;
         address_strap_pin_res <= ra;
         cfg_strap_level <= lc;
         cfg_strap_res <= rc;
         repeat (10) @(posedge clk);
         rst_n <= 1'h1;
         @(posedge clk);
         while (strap_done !== 1'h1) @(posedge clk);
         repeat (3) @(posedge clk);
      end
   endtask

   // A peer frame takes ten slots of eight cycles; wait it out.
   task tx(input [7:0] fr);
      begin
         frame <= fr;
         send <= 1'h1;
         @(posedge clk);
         send <= 1'h0;
         repeat (90) @(posedge clk);
      end
   endtask

   // Sample each slot of our frame after the start bit at its middle.
   task rx;
      integer k;
      begin
         while (peer_event_bus_in !== 1'h0) @(posedge clk);
         repeat (4) @(posedge clk);
         for (k = 0; k < 9; k = k + 1) begin
            repeat (8) @(posedge clk);
            f = {f[7:0], peer_event_bus_in};
         end
      end
   endtask

   task t_straps;
      integer i;
      reg [6:0] ea;
      reg [2:0] er;
      begin
         for (i = 0; i < 18; i = i + 1) begin
            ea = (i < 3) ? 7'h20 + i : 7'h2C + i;
            er = (i < 15) ? i / 3 : 0;
            boot(i < 3 ? i : 3, i + 12, i < 15 ? 3 : i - 15, i);
            `CHK(bus_addr, ea)
            `CHK(phase_offset, {1'h0, ea[2:0], 1'h0})
            `CHK(seq_role, er)
            `CHK(sync_dir, (i < 15) ? i % 3 : i - 15)
            address_strap_pin_level <= ~address_strap_pin_level;
            cfg_strap_res <= ~cfg_strap_res;
            repeat (4) @(posedge clk);
            `CHK({bus_addr, seq_role}, {ea, er})
         end
         $display("t_straps done");
      end
   endtask

   task t_phase;
      begin
         boot(2'h1, 5'h00, 2'h0, 5'h00);
         wr(`SSQ_OFF_PHASE, 32'h00000110);
         rd(`SSQ_OFF_PHASE);
         `CHK(d[20:16], 5'h10)
         wr(`SSQ_OFF_INT_MASK, 32'h00000004);
         wr(`SSQ_OFF_PHASE, 32'h00000111);
         `CHK({phase_offset, irq, fault_alert_line_n}, 7'h42)
         wr(`SSQ_OFF_INT_STAT, 32'h00000004);
         `CHK({irq, fault_alert_line_n}, 2'h1)
         wr(8'h18, 32'h00000001);
         `CHK(r, 2'h2)
         rd(`SSQ_OFF_STRAP);
         `CHK(d, 32'h00010021)
         rd(8'h18);
         `CHK(r, 2'h2)
         boot(2'h1, 5'h00, 2'h3, 5'h04);
         wr(`SSQ_OFF_PHASE, 32'h00000105);
         `CHK(phase_offset, 5'h02)
         wr(`SSQ_OFF_CHAIN, 32'h00010000);
         `CHK(phase_offset, 5'h05)
         $display("t_phase done");
      end
   endtask

   // Middle member at 0x21: waits for 0x20 on the way up, 0x22 going down.
   task t_seq;
      begin
         boot(2'h1, 5'h00, 2'h3, 5'h0A);
         enable_pin <= 1'h1;
         tx(8'h47);
         `CHK(rail_on, 1'h0)
         tx(8'h41);
         rx;
         `CHK({rail_on, f}, 10'h287)
         enable_pin <= 1'h0;
         tx(8'h46);
         `CHK(rail_on, 1'h1)
         tx(8'h44);
         rx;
         `CHK({rail_on, f}, 10'h085)
         $display("t_seq done");
      end
   endtask

   // The whole run needs about 1200 cycles; allow well over ten times that.
   initial begin
      #200000;
      fails = fails + 1;
      test_done;
   end

   initial begin
      t_straps;
      t_phase;
      t_seq;
      test_done;
   end
endmodule // tb_strap_address_phase_sequencer
